// [core/fragt_pkg.sv]
// shared constants and types for the flash register access gate
package fragt_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 32;
   localparam int HTRANS_NONSEQ_BIT = 1;

   // register byte offsets inside the register window
   localparam logic [7:0] OFF_CLKDIV = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_CONFIG = 8'h08;
   localparam logic [7:0] OFF_COMMAND = 8'h0C;

   // clock_divider_control fields
   localparam int CLKDIV_LOADED_BIT = 7;
   localparam int CLKDIV_LOCK_BIT = 6;
   localparam int DIV_W = 6;
   localparam logic [7:0] CLKDIV_RESET = 8'h00;

   // status and config fields
   localparam int STAT_CCF_BIT = 0;
   localparam int STAT_INIT_BIT = 1;
   localparam int CFG_RES_SEL_BIT = 0;
   localparam int CMD_LEN_W = 16;

   // cycles of the initialisation phase after reset
   localparam int INIT_CYCLES_DEF = 16;

   // global byte address map of the memory
   localparam logic [ADDR_W-1:0] REGS_LO = 18'h00000;
   localparam logic [ADDR_W-1:0] REGS_HI = 18'h003FF;
   localparam logic [ADDR_W-1:0] EE_LO = 18'h00400;
   localparam logic [ADDR_W-1:0] EE_HI = 18'h013FF;
   localparam logic [ADDR_W-1:0] WIN_LO = 18'h04000;
   localparam logic [ADDR_W-1:0] WIN_HI = 18'h07FFF;
   localparam logic [ADDR_W-1:0] PF_LO = 18'h08000;
   localparam logic [ADDR_W-1:0] PF_HI = 18'h3FFFF;

   typedef enum logic [2:0] {
      FRAGT_RGN_NONE,
      FRAGT_RGN_REGS,
      FRAGT_RGN_EEPROM,
      FRAGT_RGN_RESOURCE,
      FRAGT_RGN_PFLASH
   } fragt_region_t;

   typedef struct packed {
      logic valid;
      fragt_region_t region;
      logic [ADDR_W-1:0] offset;
   } fragt_decode_t;

   typedef struct packed {
      logic write;
      logic [7:0] offset;
   } fragt_access_t;
endpackage : fragt_pkg

// [core/fragt_top.sv]
// register gate, clock divider, timed command and address decoder of the flash controller
// Notes on behaviour
// - writes to unimplemented or reserved locations are ignored; such reads return zero
// - while the command-complete flag is 0 after initialisation, register writes change nothing
// - writes succeed when the flag is 1 and, except to the command register, during post-reset initialisation
// - divider bit 7 is read-only, set once the divider register is written
// - divider bit 6 locks high, freezing the divider field in normal mode
// - in special mode bits 6..0 are freely writable; bit 7 never
// - a reset aborts a running command at once
// - window 0x0_4000-0x0_7FFF maps to program array or resource area by select
// - program array occupies one contiguous region ending at 0x3_FFFF
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module fragt_top #(
   parameter int INIT_CYCLES = fragt_pkg::INIT_CYCLES_DEF
) (
   input wire logic hclk, // bus clock, 40 MHz
   input wire logic hresetn, // asynchronous reset, active low
   input wire logic ce, // clock enable, freezes all state when low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size, word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   input wire logic special_mode_pin, // special mode strap, asynchronous
   input wire logic [17:0] nvm_addr, // global byte address to decode
   input wire logic nvm_addr_valid, // nvm_addr is meaningful
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always OKAY
   output logic command_complete_flag, // no command running
   output logic timing_tick, // one-cycle tick, about 1 MHz
   output fragt_pkg::fragt_decode_t decode_out // region of nvm_addr
);
   localparam int INIT_W = $clog2(INIT_CYCLES + 1);
   localparam logic [INIT_W-1:0] INIT_LAST = INIT_W'(INIT_CYCLES - 1);

   logic [1:0] special_sync_reg;
   logic special_mode;
   logic pend_reg;
   fragt_pkg::fragt_access_t acc_reg;
   logic [31:0] hrdata_reg;
   logic hreadyout_reg;
   logic init_reg;
   logic [INIT_W-1:0] init_cnt_reg;
   logic ccf_reg;
   logic loaded_reg;
   logic lock_reg;
   logic [fragt_pkg::DIV_W-1:0] div_reg;
   logic res_sel_reg;
   logic [fragt_pkg::DIV_W-1:0] tick_cnt_reg;
   logic tick_reg;
   logic [fragt_pkg::CMD_LEN_W-1:0] cmd_cnt_reg;
   fragt_pkg::fragt_decode_t decode_reg;
   logic addr_take;
   logic commit;
   logic wr_commit;
   logic wr_allowed;
   logic [7:0] clkdiv_view;
   logic [31:0] rd_next;
   logic acc_hit_reg;
   logic wr_clkdiv;
   logic wr_config;
   logic wr_command;
   logic div_open;

   function automatic logic in_range(
      input logic [fragt_pkg::ADDR_W-1:0] a,
      input logic [fragt_pkg::ADDR_W-1:0] lo,
      input logic [fragt_pkg::ADDR_W-1:0] hi
   );
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // one decode for every register write strobe
   function automatic logic write_to(
      input logic strobe,
      input logic [7:0] off,
      input logic [7:0] target
   );
      write_to = strobe && (off == target);
   endfunction : write_to

   // strap from outside the clock domain: two flops before use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         special_sync_reg <= 2'h0;
      end else if (ce) begin
         special_sync_reg <= {special_sync_reg[0], special_mode_pin};
      end
   end
   assign special_mode = special_sync_reg[1];

   // bus slave: one wait state, data phase ends on the edge after commit
   assign addr_take = hsel && hready && htrans[fragt_pkg::HTRANS_NONSEQ_BIT] && hreadyout_reg;
   assign commit = pend_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_reg <= 1'b0;
      end else if (ce) begin
         if (commit) begin
            pend_reg <= 1'b0;
         end else if (addr_take) begin
            pend_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout_reg <= 1'b1;
      end else if (ce) begin
         if (commit) begin
            hreadyout_reg <= 1'b1;
         end else if (addr_take) begin
            hreadyout_reg <= 1'b0;
         end
      end
   end

   // only the lowest 256 bytes hold registers; anything above would alias otherwise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_reg <= '0;
         acc_hit_reg <= 1'b0;
      end else if (ce && !commit && addr_take) begin
         acc_reg.write <= hwrite;
         acc_reg.offset <= haddr[7:0];
         acc_hit_reg <= (haddr[31:8] == '0);
      end
   end

   // register writes pass only while idle or initialising
   assign wr_allowed = ccf_reg || init_reg;
   assign wr_commit = commit && acc_reg.write && acc_hit_reg && wr_allowed;

   assign wr_clkdiv = write_to(wr_commit, acc_reg.offset, fragt_pkg::OFF_CLKDIV);
   assign wr_config = write_to(wr_commit, acc_reg.offset, fragt_pkg::OFF_CONFIG);
   assign wr_command = write_to(wr_commit, acc_reg.offset, fragt_pkg::OFF_COMMAND);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_reg <= 1'b1;
         init_cnt_reg <= '0;
      end else if (ce && init_reg) begin
         if (init_cnt_reg == INIT_LAST) begin
            init_reg <= 1'b0;
         end
         init_cnt_reg <= init_cnt_reg + INIT_W'(1);
      end
   end

   // loaded follows any accepted divider write, even one the lock blocks
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loaded_reg <= fragt_pkg::CLKDIV_RESET[fragt_pkg::CLKDIV_LOADED_BIT];
      end else if (ce && wr_clkdiv) begin
         loaded_reg <= 1'b1;
      end
   end

   // a held lock only yields to special mode or to reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lock_reg <= fragt_pkg::CLKDIV_RESET[fragt_pkg::CLKDIV_LOCK_BIT];
      end else if (ce && wr_clkdiv) begin
         if (special_mode) begin
            lock_reg <= hwdata[fragt_pkg::CLKDIV_LOCK_BIT];
         end else begin
            lock_reg <= lock_reg | hwdata[fragt_pkg::CLKDIV_LOCK_BIT];
         end
      end
   end

   assign div_open = special_mode || !lock_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_reg <= fragt_pkg::CLKDIV_RESET[fragt_pkg::DIV_W-1:0];
      end else if (ce && wr_clkdiv && div_open) begin
         div_reg <= hwdata[fragt_pkg::DIV_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         res_sel_reg <= 1'b0;
      end else if (ce && wr_config) begin
         res_sel_reg <= hwdata[fragt_pkg::CFG_RES_SEL_BIT];
      end
   end

   // tick divides the bus clock by divider field plus one
   // a field lowered below the count wraps at once rather than running to overflow
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_reg <= '0;
      end else if (ce) begin
         if (tick_cnt_reg >= div_reg) begin
            tick_cnt_reg <= '0;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + fragt_pkg::DIV_W'(1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_reg <= 1'b0;
      end else if (ce) begin
         tick_reg <= (tick_cnt_reg >= div_reg);
      end
   end

   // timed command: flag low for the written number of ticks
   // flag reads 0 during initialisation, as the reset sequence still owns the array
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ccf_reg <= 1'b0;
      end else if (ce) begin
         if (init_reg) begin
            ccf_reg <= (init_cnt_reg == INIT_LAST);
         end else if (!ccf_reg) begin
            if (cmd_cnt_reg == '0) begin
               ccf_reg <= 1'b1;
            end
         end else if (wr_command) begin
            ccf_reg <= 1'b0;
         end
      end
   end

   // reset drops the remaining count, so an aborted command never resumes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cmd_cnt_reg <= '0;
      end else if (ce && !init_reg) begin
         if (!ccf_reg) begin
            if (cmd_cnt_reg != '0 && tick_reg) begin
               cmd_cnt_reg <= cmd_cnt_reg - fragt_pkg::CMD_LEN_W'(1);
            end
         end else if (wr_command) begin
            cmd_cnt_reg <= hwdata[fragt_pkg::CMD_LEN_W-1:0];
         end
      end
   end

   // read view; unmapped offsets read zero, unmapped writes fall through
   assign clkdiv_view = {loaded_reg, lock_reg, div_reg};

   always_comb begin
      rd_next = '0;
      if (acc_hit_reg) begin
         case (acc_reg.offset)
            fragt_pkg::OFF_CLKDIV: rd_next[7:0] = clkdiv_view;
            fragt_pkg::OFF_STATUS: begin
               rd_next[fragt_pkg::STAT_CCF_BIT] = ccf_reg;
               rd_next[fragt_pkg::STAT_INIT_BIT] = init_reg;
            end
            fragt_pkg::OFF_CONFIG: rd_next[fragt_pkg::CFG_RES_SEL_BIT] = res_sel_reg;
            fragt_pkg::OFF_COMMAND: rd_next[fragt_pkg::CMD_LEN_W-1:0] = cmd_cnt_reg;
            default: rd_next = '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= '0;
      end else if (ce && commit && !acc_reg.write) begin
         hrdata_reg <= rd_next;
      end
   end

   // address decoder
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         decode_reg <= '0;
      end else if (ce) begin
         decode_reg.valid <= nvm_addr_valid;
         decode_reg.offset <= nvm_addr;
         if (!nvm_addr_valid) begin
            decode_reg.region <= fragt_pkg::FRAGT_RGN_NONE;
         end else if (in_range(nvm_addr, fragt_pkg::REGS_LO, fragt_pkg::REGS_HI)) begin
            decode_reg.region <= fragt_pkg::FRAGT_RGN_REGS;
         end else if (in_range(nvm_addr, fragt_pkg::EE_LO, fragt_pkg::EE_HI)) begin
            decode_reg.region <= fragt_pkg::FRAGT_RGN_EEPROM;
         end else if (in_range(nvm_addr, fragt_pkg::WIN_LO, fragt_pkg::WIN_HI)) begin
            decode_reg.region <= res_sel_reg ? fragt_pkg::FRAGT_RGN_RESOURCE
                                             : fragt_pkg::FRAGT_RGN_PFLASH;
         end else if (in_range(nvm_addr, fragt_pkg::PF_LO, fragt_pkg::PF_HI)) begin
            decode_reg.region <= fragt_pkg::FRAGT_RGN_PFLASH;
         end else begin
            decode_reg.region <= fragt_pkg::FRAGT_RGN_NONE;
         end
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = 1'b0;
   assign command_complete_flag = ccf_reg;
   assign timing_tick = tick_reg;
   assign decode_out = decode_reg;
endmodule : fragt_top

// [verif/fragt_top_props.sv]
// port checker for the flash register access gate
`timescale 1ns/10ps
module fragt_top_props #(
   parameter int INIT_CYCLES = 16
) (
   input wire logic hclk, // bus clock
   input wire logic hresetn, // reset, active low
   input wire logic ce, // clock enable
   input wire logic hsel, // select
   input wire logic [1:0] htrans, // transfer type
   input wire logic hready, // bus ready
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic command_complete_flag, // idle flag
   input wire logic [17:0] nvm_addr, // decode address
   input wire logic nvm_addr_valid, // decode request
   input wire fragt_pkg::fragt_decode_t decode_out // decode result
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire dv = nvm_addr_valid && ce;
   a_resp_okay: assert property (hresp == 1'h0) else $error("hresp not okay");
   a_one_wait: assert property (hsel && htrans[1] && hready && hreadyout && ce
      |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
   a_init_low: assert property ($rose(hresetn) |-> !command_complete_flag [*3])
      else $error("flag high in init");
   a_reset_abort: assert property (disable iff (1'h0) !hresetn |-> !command_complete_flag)
      else $error("flag high in reset");
   a_win_map: assert property (dv && nvm_addr inside {[18'h04000:18'h07FFF]} |=>
      decode_out.region inside {fragt_pkg::FRAGT_RGN_RESOURCE, fragt_pkg::FRAGT_RGN_PFLASH})
      else $error("window misdecoded");
   a_pf_map: assert property (dv && nvm_addr >= 18'h08000 |=>
      decode_out.region == fragt_pkg::FRAGT_RGN_PFLASH) else $error("array misdecoded");
   a_gap_none: assert property (dv && nvm_addr inside {[18'h01400:18'h03FFF]} |=>
      decode_out.region == fragt_pkg::FRAGT_RGN_NONE) else $error("gap decoded");
   a_regs_map: assert property (dv && nvm_addr <= 18'h003FF |=>
      decode_out.region == fragt_pkg::FRAGT_RGN_REGS) else $error("regs misdecoded");
endmodule : fragt_top_props
bind fragt_top fragt_top_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (.hclk(hclk),
   .hresetn(hresetn), .ce(ce), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .command_complete_flag(command_complete_flag),
   .nvm_addr(nvm_addr), .nvm_addr_valid(nvm_addr_valid), .decode_out(decode_out));

// [verif/fragt_host.sv]
// bus host model issuing single word transfers
`timescale 1ns/10ps
module fragt_host (
   input wire logic hclk, // bus clock
   input wire logic hready, // bus ready
   input wire logic [31:0] hrdata, // read data
   output logic hsel, // slave select
   output logic [31:0] haddr, // byte address
   output logic [1:0] htrans, // transfer type
   output logic hwrite, // write when high
   output logic [31:0] hwdata // write data
);
   initial begin
      hsel = 1'h0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hwdata = 32'h0;
   end
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic to);
      int n;
      n = 0;
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'h1 && n < 64);
      htrans <= 2'h0;
      hsel <= 1'h0;
      // released lines toggle so stale values are never trusted
      haddr <= ~a;
      hwrite <= ~w;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'h1 && n < 64);
      q = hrdata;
      hwdata <= ~d;
      to = (n >= 64);
   endtask : xfer
endmodule : fragt_host

// [verif/test_fragt_top.sv]
// bench for the flash register access gate
`timescale 1ns/10ps
module test_fragt_top;
   localparam logic [7:0] DIV = fragt_pkg::OFF_CLKDIV;
   localparam logic [7:0] STS = fragt_pkg::OFF_STATUS;
   localparam logic [7:0] CFG = fragt_pkg::OFF_CONFIG;
   localparam logic [7:0] CMD = fragt_pkg::OFF_COMMAND;
   logic hclk = 1'h0;
   logic hresetn = 1'h0;
   logic smode = 1'h0;
   logic [17:0] na = 18'h00000;
   logic nav = 1'h0;
   logic hsel, hwrite, hrdy, hresp, ccf, to, tk;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, q;
   fragt_pkg::fragt_decode_t dec;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   always #12.5 hclk = ~hclk;
   always @(posedge hclk) cyc++;
   fragt_top #(.INIT_CYCLES(4)) DUT (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hrdy), .special_mode_pin(smode), .nvm_addr(na), .nvm_addr_valid(nav),
      .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .command_complete_flag(ccf),
      .timing_tick(tk), .decode_out(dec));
   fragt_host host (.hclk(hclk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic end_sim;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_sim
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      host.xfer(w, {24'h000000, a}, d, q, to);
      if (to) begin
         errors++;
         end_sim;
      end
   endtask : acc
   task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
      acc(1'h0, a, 32'h0);
      check(what, q, exp);
   endtask : rc
   task automatic wait_ccf;
      for (int n = 0; ccf !== 1'h1; n++) begin
         @(posedge hclk);
         if (n > 2000) begin
            errors++;
            end_sim;
         end
      end
   endtask : wait_ccf
   task automatic t_div;
      rc("div reset", DIV, 32'h00);
      acc(1'h1, DIV, 32'h05);
      rc("div loaded", DIV, 32'h85);
      acc(1'h1, DIV, 32'hCA);
      rc("div lock", DIV, 32'hCA);
      acc(1'h1, DIV, 32'h03);
      rc("div frozen", DIV, 32'hCA);
      smode <= 1'h1;
      // strap passes a two-flop synchroniser
      repeat (3) @(posedge hclk);
      acc(1'h1, DIV, 32'h03);
      rc("div special", DIV, 32'h83);
      smode <= 1'h0;
      repeat (3) @(posedge hclk);
   endtask : t_div
   task automatic t_busy;
      int c0;
      int n;
      // divider field 3 gives one tick every four cycles
      n = 0;
      repeat (40) begin
         @(posedge hclk);
         n += tk;
      end
      check("tick count", n, 32'd10);
      acc(1'h1, CFG, 32'h1);
      acc(1'h1, 8'h40, 32'hFF);
      rc("unmapped", 8'h40, 32'h0);
      acc(1'h1, CMD, 32'h5);
      c0 = cyc;
      rc("status busy", STS, 32'h0);
      acc(1'h1, CFG, 32'h0);
      rc("cfg kept", CFG, 32'h1);
      wait_ccf;
      // five ticks of four cycles each, with some phase slack
      check("busy len", 32'((cyc - c0) inside {[16:26]}), 32'h1);
      rc("status idle", STS, 32'h1);
      acc(1'h1, CFG, 32'h0);
      rc("cfg idle", CFG, 32'h0);
   endtask : t_busy
   task automatic t_dec;
      logic [17:0] ad [7] = '{18'h04000, 18'h07FFF, 18'h08000, 18'h3FFFF, 18'h00400,
         18'h01400, 18'h00010};
      logic [2:0] ex [7] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h2, 3'h0, 3'h1};
      for (int s = 0; s < 2; s++) begin
         acc(1'h1, CFG, 32'(s));
         for (int i = 0; i < 7; i++) begin
            na <= ad[i];
            nav <= 1'h1;
            @(posedge hclk);
            #1 check("region", dec.region, (s == 1 && i < 2) ? 3'h3 : ex[i]);
            check("offset", 32'(dec.offset), 32'(ad[i]));
            check("valid", 32'(dec.valid), 32'h1);
         end
      end
      nav <= 1'h0;
   endtask : t_dec
   task automatic t_rst;
      acc(1'h1, DIV, 32'h40);
      acc(1'h1, CMD, 32'h20);
      repeat (3) @(posedge hclk);
      hresetn <= 1'h0;
      @(posedge hclk);
      #1 check("abort", {31'h0, ccf}, 32'h0);
      @(posedge hclk);
      hresetn <= 1'h1;
      acc(1'h1, DIV, 32'h02);
      rc("init write", DIV, 32'h82);
      wait_ccf;
      rc("cmd aborted", CMD, 32'h0);
   endtask : t_rst
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      wait_ccf;
      t_div;
      t_busy;
      t_dec;
      t_rst;
      end_sim;
   end
endmodule : test_fragt_top
